// File: mitc_consts.svh
// Timing constants and datapath values for the instruction timing core.
// Included by the package and the core; definitions only.
`ifndef MITC_CONSTS_SVH
`define MITC_CONSTS_SVH
`define MITC_PHASES     3'h4
`define MITC_PHASE_LAST 2'h3
`define MITC_PHASE_EXEC 2'h2
`define MITC_BYTE_MAX   9'h0_0FF
`define MITC_ONE        8'h01
`define MITC_ZERO       8'h00
`define MITC_NIB_MASK   5'h0F
`define MITC_SYS_MHZ    200
`endif

// File: mitc_core.sv
// Instruction timing core: four-phase cycle, one or two cycle instructions, ALU and flags.
// Assumes the program memory supplies a decoded op and operand synchronous to i_core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "mitc_consts.svh"
// How it works
// - Instruction cycle is four system clocks.
// - Plain instructions finish in one cycle.
// - Branch, call, table read take two cycles.
// - Jump, call, return, interrupt-return add cycle.
// - Writing program counter low byte adds cycle, except when the op is a no-op.
// - Skip adds cycle only when taken.
// - Add carries above 255, subtract borrows below 0.
// - Increment and decrement change by one.
// - Logical ops set zero on zero result.
// - Rotates move exactly one bit.
// - Through-carry rotates pass bit into carry.
// - Data passes through the accumulator.
// - Three move forms are supported.
// - AND, OR, XOR, complement each distinct.
// - Add/subtract update zero, carry, auxiliary, overflow.
module mitc_core
  import mitc_pkg::*;
#(
  parameter int unsigned DATA_W = 8
) (
  input  wire logic           i_core_clk,
  input  wire logic           i_rst,
  input  wire mitc_op_t       i_op,
  input  wire logic [7:0]     i_operand,
  input  wire logic           i_dest_program_counter_low_byte,
  output logic [7:0]          o_acc,
  output logic [7:0]          o_mem_wdata,
  output logic                o_mem_we,
  output logic                o_fetch,
  output logic                o_flush,
  output logic [1:0]          o_phase,
  output logic                o_zero_flag,
  output logic                o_carry_flag,
  output logic                o_auxiliary_carry_flag,
  output logic                o_overflow_flag
);

  if (DATA_W != 8) begin : g_width_check
    $error("mitc_core serves an 8-bit datapath only");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Phase counter and cycle state.

  logic [1:0]  phase_r, phase_nxt;
  mitc_state_t state_r, state_nxt;
  logic        cyc_end;
  logic        extra;

  assign cyc_end = (phase_r == `MITC_PHASE_LAST);

  always_comb begin
    phase_nxt = phase_r + 2'h1;
    state_nxt = state_r;
    if (cyc_end) begin
      case (state_r)
        MITC_RUN:   state_nxt = extra ? MITC_FLUSH : MITC_RUN;
        MITC_FLUSH: state_nxt = MITC_RUN;
        default:    state_nxt = MITC_RUN;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_r <= 2'h0;
      state_r <= MITC_RUN;
    end else begin
      phase_r <= phase_nxt;
      state_r <= state_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Datapath. The result is computed in phase two; a flushed cycle executes nothing,
  // which is why the prefetched word is simply dropped rather than held.

  logic [7:0] acc_r, acc_nxt, wd_r, wd_nxt;
  logic       we_r, we_nxt, z_r, z_nxt, c_r, c_nxt;
  logic       auxiliary_carry_flag_r, auxiliary_carry_flag_nxt;
  logic       overflow_flag_r, overflow_flag_nxt;
  logic       fetch_r, fetch_nxt, flush_r, flush_nxt;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] res, opb;
  logic       cin, is_sub, arith, wr_mem, skip;

  always_comb begin
    res    = acc_r;
    is_sub = (i_op == MITC_SUB) || (i_op == MITC_SBC);
    cin    = ((i_op == MITC_ADC) && c_r) || (i_op == MITC_SUB) ||
             ((i_op == MITC_SBC) && c_r);
    opb    = is_sub ? ~i_operand : i_operand;
    sum    = {1'b0, acc_r} + {1'b0, opb} + {8'h00, cin};
    nib    = {1'b0, acc_r[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    arith  = (i_op inside {MITC_ADD, MITC_ADC, MITC_SUB, MITC_SBC});
    wr_mem = 1'b0;
    skip   = 1'b0;
    z_nxt  = z_r;
    c_nxt  = c_r;
    auxiliary_carry_flag_nxt = auxiliary_carry_flag_r;
    overflow_flag_nxt        = overflow_flag_r;
    case (i_op)
      MITC_MOV_M2A, MITC_MOV_IMM: res = i_operand;
      MITC_MOV_A2M:               wr_mem = 1'b1;
      MITC_ADD, MITC_ADC, MITC_SUB, MITC_SBC: res = sum[7:0];
      MITC_AND: res = acc_r & i_operand;
      MITC_OR:  res = acc_r | i_operand;
      MITC_XOR: res = acc_r ^ i_operand;
      MITC_COMPLEMENT_INSTR: res = ~i_operand;
      MITC_INC: res = i_operand + `MITC_ONE;
      MITC_DEC: res = i_operand - `MITC_ONE;
      MITC_RR:  res = {i_operand[0], i_operand[7:1]};
      MITC_RL:  res = {i_operand[6:0], i_operand[7]};
      MITC_ROTATE_RIGHT_THROUGH_CARRY: begin
        res   = {c_r, i_operand[7:1]};
        c_nxt = i_operand[0];
      end
      MITC_ROTATE_LEFT_THROUGH_CARRY: begin
        res   = {i_operand[6:0], c_r};
        c_nxt = i_operand[7];
      end
      MITC_SKZ:  skip = (i_operand == `MITC_ZERO);
      MITC_SKNZ: skip = (i_operand != `MITC_ZERO);
      default:   res = acc_r;
    endcase
    if (arith) begin
      z_nxt  = (sum[7:0] == `MITC_ZERO);
      c_nxt  = sum[8];
      auxiliary_carry_flag_nxt = nib[4];
      overflow_flag_nxt        = (acc_r[7] == opb[7]) && (sum[7] != acc_r[7]);
    end else if (i_op inside {MITC_AND, MITC_OR, MITC_XOR, MITC_COMPLEMENT_INSTR, MITC_INC,
                              MITC_DEC}) begin
      z_nxt = (res == `MITC_ZERO);
    end
    extra = (i_op inside {MITC_JMP, MITC_CALL, MITC_RET, MITC_RETURN_FROM_INTERRUPT_INSTR,
                          MITC_TABRD})
            || (i_dest_program_counter_low_byte && (i_op != MITC_NOP))
            || skip;
    acc_nxt   = acc_r;
    wd_nxt    = wd_r;
    we_nxt    = 1'b0;
    fetch_nxt = 1'b0;
    flush_nxt = flush_r;
    if (cyc_end) begin
      fetch_nxt = 1'b1;
      flush_nxt = (state_r == MITC_RUN) && extra;
    end
    if ((phase_r == `MITC_PHASE_EXEC) && (state_r == MITC_RUN)) begin
      if (wr_mem || i_dest_program_counter_low_byte) begin
        wd_nxt = wr_mem ? acc_r : res;
        we_nxt = 1'b1;
      end else begin
        acc_nxt = res;
      end
    end else begin
      z_nxt  = z_r;
      c_nxt  = c_r;
      auxiliary_carry_flag_nxt = auxiliary_carry_flag_r;
      overflow_flag_nxt        = overflow_flag_r;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_r   <= 8'h00;
      wd_r    <= 8'h00;
      we_r    <= 1'b0;
      z_r     <= 1'b0;
      c_r     <= 1'b0;
      auxiliary_carry_flag_r <= 1'b0;
      overflow_flag_r        <= 1'b0;
      fetch_r <= 1'b0;
      flush_r <= 1'b0;
    end else begin
      acc_r   <= acc_nxt;
      wd_r    <= wd_nxt;
      we_r    <= we_nxt;
      z_r     <= z_nxt;
      c_r     <= c_nxt;
      auxiliary_carry_flag_r <= auxiliary_carry_flag_nxt;
      overflow_flag_r        <= overflow_flag_nxt;
      fetch_r <= fetch_nxt;
      flush_r <= flush_nxt;
    end
  end

  assign o_acc                  = acc_r;
  assign o_mem_wdata            = wd_r;
  assign o_mem_we               = we_r;
  assign o_fetch                = fetch_r;
  assign o_flush                = flush_r;
  assign o_phase                = phase_r;
  assign o_zero_flag            = z_r;
  assign o_carry_flag           = c_r;
  assign o_auxiliary_carry_flag = auxiliary_carry_flag_r;
  assign o_overflow_flag        = overflow_flag_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_jump_seen;
    cyc_end && (state_r == MITC_RUN) && extra;
  endsequence

  chk_phase_wraps: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cyc_end |=> (phase_r == 2'h0) ##3 cyc_end) else $error("phase period not four");
  chk_fetch_every: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cyc_end |=> o_fetch ##1 !o_fetch [*3]) else $error("fetch pulse spacing wrong");
  chk_single_cycle: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (cyc_end && state_r == MITC_RUN && !extra) |=> (state_r == MITC_RUN))
    else $error("plain instruction took extra cycle");
  chk_extra_flush: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_jump_seen |=> (state_r == MITC_FLUSH) [*4] ##1 (state_r == MITC_RUN))
    else $error("extra cycle not exactly one");
  chk_low_byte_extra: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (cyc_end && state_r == MITC_RUN && i_dest_program_counter_low_byte && i_op != MITC_NOP)
    |=> o_flush) else $error("program counter low write no extra cycle");
  chk_skip_cycle: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (cyc_end && state_r == MITC_RUN && i_op == MITC_SKZ) |=>
    (o_flush == ($past(i_operand) == `MITC_ZERO))) else $error("skip timing wrong");
  chk_add_carry: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (phase_r == `MITC_PHASE_EXEC && state_r == MITC_RUN && i_op == MITC_ADD &&
     !i_dest_program_counter_low_byte) |=>
    (o_carry_flag == (({1'b0, $past(acc_r)} + {1'b0, $past(i_operand)}) > `MITC_BYTE_MAX)))
    else $error("add carry wrong");
  chk_inc_one: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (phase_r == `MITC_PHASE_EXEC && state_r == MITC_RUN && i_op == MITC_INC &&
     !i_dest_program_counter_low_byte) |=>
    (o_acc == $past(i_operand) + `MITC_ONE)) else $error("increment not by one");
  chk_logic_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (phase_r == `MITC_PHASE_EXEC && state_r == MITC_RUN && i_op == MITC_AND &&
     !i_dest_program_counter_low_byte) |=>
    (o_zero_flag == (o_acc == `MITC_ZERO))) else $error("zero flag wrong");
  chk_rotate_carry: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (phase_r == `MITC_PHASE_EXEC && state_r == MITC_RUN &&
     i_op == MITC_ROTATE_RIGHT_THROUGH_CARRY && !i_dest_program_counter_low_byte) |=>
    (o_carry_flag == $past(i_operand[0])) && (o_acc[6:0] == $past(i_operand[7:1])))
    else $error("rotate through carry wrong");

endmodule // mitc_core
`default_nettype wire

// File: mitc_pkg.sv
// Types for the instruction timing core: the decoded operation and the cycle state.
// Assumes mitc_consts.svh is on the include path.
`include "mitc_consts.svh"
package mitc_pkg;
  typedef enum logic [4:0] {
    MITC_NOP, MITC_MOV_M2A, MITC_MOV_A2M, MITC_MOV_IMM,
    MITC_ADD, MITC_ADC, MITC_SUB, MITC_SBC,
    MITC_AND, MITC_OR, MITC_XOR, MITC_COMPLEMENT_INSTR,
    MITC_INC, MITC_DEC, MITC_RR, MITC_RL,
    MITC_ROTATE_RIGHT_THROUGH_CARRY, MITC_ROTATE_LEFT_THROUGH_CARRY,
    MITC_JMP, MITC_CALL, MITC_RET, MITC_RETURN_FROM_INTERRUPT_INSTR, MITC_TABRD,
    MITC_SKZ, MITC_SKNZ
  } mitc_op_t;
  typedef enum logic [0:0] {MITC_RUN, MITC_FLUSH} mitc_state_t;
endpackage

// File: mitc_prog_mem.sv
// Program memory model for the instruction timing core: a random instruction stream.
// Assumes the bench seeds $urandom once and that the core pulses i_fetch at phase 0.
`timescale 1ns/1ps
`default_nettype none
module mitc_prog_mem
  import mitc_pkg::*;
(
  input  wire logic     i_core_clk,
  input  wire logic     i_rst,
  input  wire logic     i_fetch,
  output var mitc_op_t  o_op,
  output var logic[7:0] o_operand,
  output var logic      o_dest_program_counter_low_byte
);
  mitc_op_t w;
  initial begin
    o_op = MITC_NOP;
    o_operand = 8'h00;
    o_dest_program_counter_low_byte = 1'b0;
  end
  // A new word follows every fetch, flushed or not, so a discarded word may be a jump.
  always @(negedge i_core_clk) begin
    if (i_rst || i_fetch) begin
      w = mitc_op_t'(5'($urandom % 25));
      o_op <= w;
      o_operand <= ($urandom % 4 == 0) ? 8'h00 : 8'($urandom);
      // Any operation may aim at the low address byte, so every result path meets it.
      o_dest_program_counter_low_byte <= ($urandom % 4 == 0);
    end
  end
endmodule // mitc_prog_mem
`default_nettype wire

// File: tb.sv
// Self-checking bench for the timing core against an integer model.
// Assumes the core executes at the edge that ends phase 2 of each instruction cycle.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mitc_pkg::*;
  logic       i_core_clk = 1'b0;
  logic       i_rst      = 1'b1;
  mitc_op_t   op;
  logic [7:0] arg, o_acc, o_mem_wdata;
  logic [1:0] o_phase;
  logic       dest_low, o_mem_we, o_fetch, o_flush, zf, cf, af, vf;
  int         fail_count = 0;
  int         num_checks = 0;
  int         a, c, z, h, v, r, m, ph, xfl, nx, we, wd, a0;
  always #2.5 i_core_clk = ~i_core_clk;
  mitc_core mitc_core_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_op(op), .i_operand(arg),
    .i_dest_program_counter_low_byte(dest_low), .o_acc(o_acc),
    .o_mem_wdata(o_mem_wdata), .o_mem_we(o_mem_we),
    .o_fetch(o_fetch), .o_flush(o_flush), .o_phase(o_phase), .o_zero_flag(zf),
    .o_carry_flag(cf), .o_auxiliary_carry_flag(af), .o_overflow_flag(vf));
  mitc_prog_mem mitc_prog_mem_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_fetch(o_fetch),
    .o_op(op), .o_operand(arg), .o_dest_program_counter_low_byte(dest_low));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic do_reset();
    i_rst = 1'b1;
    repeat (4) @(negedge i_core_clk);
    chk("phase", 8'(o_phase), 8'h00);
    chk("acc", o_acc, 8'h00);
    i_rst = 1'b0;
    a = 0; c = 0; z = 0; h = 0; v = 0;
    xfl = 0; nx = 0; we = 0; wd = 0; ph = 1;
  endtask
  // Runs the core's operation in the model, exactly as an executed cycle should.
  task automatic exec();
    m = arg;
    r = 0;
    a0 = a;
    case (op)
      MITC_MOV_M2A, MITC_MOV_IMM: a = m;
      MITC_MOV_A2M: begin we = 1; wd = a; end
      MITC_ADD, MITC_ADC, MITC_SUB, MITC_SBC: begin
        if (op == MITC_SUB || op == MITC_SBC) m = m ^ 255;
        r = (op == MITC_ADD) ? 0 : (op == MITC_SUB) ? 1 : c;
        h = ((a & 15) + (m & 15) + r) > 15;
        r = a + m + r;
        v = ((a ^ r) & (m ^ r) & 128) != 0;
        c = r > 255;
        a = r & 255;
        z = a == 0;
      end
      MITC_AND: r = a & m;
      MITC_OR:  r = a | m;
      MITC_XOR: r = a ^ m;
      MITC_COMPLEMENT_INSTR: r = m ^ 255;
      MITC_INC: r = (m + 1) & 255;
      MITC_DEC: r = (m + 255) & 255;
      MITC_RR:  a = (m >> 1) | ((m & 1) << 7);
      MITC_RL:  a = ((m << 1) & 255) | (m >> 7);
      MITC_ROTATE_RIGHT_THROUGH_CARRY: begin a = (m >> 1) | (c << 7); c = m & 1; end
      MITC_ROTATE_LEFT_THROUGH_CARRY: begin a = ((m << 1) & 255) | c; c = m >> 7; end
      default: ;
    endcase
    if (op inside {MITC_AND, MITC_OR, MITC_XOR, MITC_COMPLEMENT_INSTR, MITC_INC,
                   MITC_DEC}) begin
      a = r;
      z = r == 0;
    end
    // A result aimed at the low address byte leaves on the memory port instead.
    if (dest_low) begin
      we = 1;
      wd = a;
      a  = a0;
    end
  endtask
  task automatic step();
    @(negedge i_core_clk);
    chk("phase", 8'(o_phase), 8'(ph));
    chk("fetch", 8'(o_fetch), 8'(ph == 0));
    if (ph == 0) xfl = nx;
    chk("flush", 8'(o_flush), 8'(xfl));
    chk("mem_we", 8'(o_mem_we), 8'(we));
    if (we != 0) chk("wdata", o_mem_wdata, 8'(wd));
    if (ph == 3) begin
      chk("acc", o_acc, 8'(a));
      chk("zero", 8'(zf), 8'(z));
      chk("carry", 8'(cf), 8'(c));
      chk("aux", 8'(af), 8'(h));
      chk("ovf", 8'(vf), 8'(v));
    end
    we = 0;
    if (ph == 2 && xfl == 0) exec();
    // A discarded word never redirects, so a flush cycle cannot chain another flush.
    if (ph == 3) nx = (xfl == 0) && ((op inside {MITC_JMP, MITC_CALL, MITC_RET,
      MITC_RETURN_FROM_INTERRUPT_INSTR, MITC_TABRD}) || (dest_low && op != MITC_NOP) ||
      (op == MITC_SKZ && arg == 8'h00) ||
      (op == MITC_SKNZ && arg != 8'h00));
    ph = (ph + 1) % 4;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hef44));
    do_reset();
    repeat (1202) step();
    do_reset();
    repeat (1200) step();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
